// ### pos_i2c_host.sv
// I2C host model for the settings port
// Assumes a pull-up on SDA; each bus phase lasts five clocks
`timescale 1ns/1ps
module pos_i2c_host (
  input wire logic clock,
  input wire logic sda_out,
  input wire logic sda_oe,
  output logic scl,
  output logic sda,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  // ----------
  // Bus cycles
  // ----------
  logic sda_h = 1'b1;
  assign sda = sda_h && !(sda_oe && !sda_out);
  initial begin
    scl = 1'b1;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  task automatic tick();
    repeat (5) @(posedge clock);
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_h <= b;
    tick();
    scl <= 1'b1;
    tick();
    r = sda;
    scl <= 1'b0;
    tick();
  endtask
  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic start();
    sda_h <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_h <= 1'b0;
    tick();
    scl <= 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_h <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_h <= 1'b1;
    tick();
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c,
                    input logic [7:0] d, output logic ok);
    logic k;
    start();
    byte_tx({a, 1'b0}, ok);
    byte_tx(c, k);
    byte_tx(d, k);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c);
    logic k;
    logic [7:0] d;
    start();
    byte_tx({a, 1'b0}, k);
    byte_tx(c, k);
    start();
    byte_tx({a, 1'b1}, k);
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(1'b1, k);
    stop();
    rx_byte <= d;
    rx_valid <= 1'b1;
    @(posedge clock);
    rx_valid <= 1'b0;
  endtask
endmodule

// ### pos_nvm.sv
// Nonvolatile backup of the sequencing settings, one byte per slot
// Assumes writes come from the host port; read data is registered
`timescale 1ns/1ps
module pos_nvm (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_addr,
  output logic [7:0] rd_data
);
  import pos_pkg::*;

  logic [7:0] mem [0:7];

  // ------------------------------------------------------------
  // Storage, preset to the programmed defaults
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        mem[i] <= 8'h00;
      end
      mem[NVM_TON] <= DEF_TON;
      mem[NVM_SS] <= DEF_SS;
      mem[NVM_TOFF] <= DEF_TOFF;
      mem[NVM_SSTOP] <= DEF_SSTOP;
      mem[NVM_PIN] <= DEF_PIN;
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // ------------------------------------------------------------
  // Registered read
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ### pos_pkg.sv
// Constants, types and lookup functions of the power sequencer
// Assumes a 100 MHz system clock and byte-wide host settings
package pos_pkg;

  // ------------------------------------------------------------
  // Host command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_TURN_ON_DELAY = 8'h60;
  localparam logic [7:0] CMD_SOFT_START = 8'h61;
  localparam logic [7:0] CMD_TURN_OFF_DELAY = 8'h64;
  localparam logic [7:0] CMD_SOFT_STOP = 8'h65;
  localparam logic [7:0] CMD_INPUT_POWER_LIMIT = 8'h6b;
  localparam logic [7:0] CMD_STATUS_INPUT = 8'h7c;

  // ------------------------------------------------------------
  // Field layout and defaults
  // ------------------------------------------------------------
  localparam int TON_W = 2;
  localparam int SS_W = 3;
  localparam int TOFF_W = 2;
  localparam int SSTOP_W = 2;
  localparam int PIN_W = 3;
  localparam int STAT_PIN_WARN_BIT = 0;
  localparam logic [7:0] DEF_TON = 8'h00;
  localparam logic [7:0] DEF_SS = 8'h00;
  localparam logic [7:0] DEF_TOFF = 8'h00;
  localparam logic [7:0] DEF_SSTOP = 8'h00;
  localparam logic [7:0] DEF_PIN = 8'h00;
  localparam logic [6:0] DEF_I2C_ADDR = 7'h2c;

  // NVM slot of each setting
  localparam logic [2:0] NVM_TON = 3'h0;
  localparam logic [2:0] NVM_SS = 3'h1;
  localparam logic [2:0] NVM_TOFF = 3'h2;
  localparam logic [2:0] NVM_SSTOP = 3'h3;
  localparam logic [2:0] NVM_PIN = 3'h4;
  localparam logic [2:0] NVM_LAST = 3'h4;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_MS_NS = 500000;
  localparam int HALF_MS_CYCLES = HALF_MS_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [TON_W-1:0] ton;
    logic [SS_W-1:0] ss;
    logic [TOFF_W-1:0] toff;
    logic [SSTOP_W-1:0] sstop;
    logic [PIN_W-1:0] pin;
  } pos_cfg_s;

  typedef enum logic [5:0] {
    SEQ_OFF = 6'b000001,
    SEQ_TON = 6'b000010,
    SEQ_RISE = 6'b000100,
    SEQ_REG = 6'b001000,
    SEQ_TOFF = 6'b010000,
    SEQ_FALL = 6'b100000
  } pos_seq_e;

  typedef enum logic [6:0] {
    BUS_IDLE = 7'b0000001,
    BUS_ADDR = 7'b0000010,
    BUS_CMD = 7'b0000100,
    BUS_WDAT = 7'b0001000,
    BUS_ACK = 7'b0010000,
    BUS_RDAT = 7'b0100000,
    BUS_MACK = 7'b1000000
  } pos_bus_e;

  // ------------------------------------------------------------
  // Lookups, in half-millisecond units and watts
  // ------------------------------------------------------------
  function automatic logic [5:0] ton_units(input logic [TON_W-1:0] c);
    case (c)
      2'h0: ton_units = 6'h01;
      2'h1: ton_units = 6'h02;
      2'h2: ton_units = 6'h03;
      default: ton_units = 6'h04;
    endcase
  endfunction

  function automatic logic [5:0] ss_units(input logic [SS_W-1:0] c);
    case (c)
      3'h0: ss_units = 6'h02;
      3'h1: ss_units = 6'h04;
      3'h2: ss_units = 6'h08;
      3'h3: ss_units = 6'h10;
      default: ss_units = 6'h20;
    endcase
  endfunction

  function automatic logic [5:0] toff_units(input logic [TOFF_W-1:0] c);
    case (c)
      2'h0: toff_units = 6'h00;
      2'h1: toff_units = 6'h02;
      2'h2: toff_units = 6'h03;
      default: toff_units = 6'h04;
    endcase
  endfunction

  function automatic logic [5:0] sstop_units(input logic [SSTOP_W-1:0] c);
    case (c)
      2'h0: sstop_units = 6'h01;
      2'h1: sstop_units = 6'h02;
      2'h2: sstop_units = 6'h04;
      default: sstop_units = 6'h08;
    endcase
  endfunction

  function automatic logic [15:0] pin_limit(input logic [PIN_W-1:0] c);
    case (c)
      3'h0: pin_limit = 16'h01fe;
      3'h1: pin_limit = 16'h01e0;
      3'h2: pin_limit = 16'h01a4;
      3'h3: pin_limit = 16'h0168;
      3'h4: pin_limit = 16'h012c;
      3'h5: pin_limit = 16'h00f0;
      3'h6: pin_limit = 16'h00b4;
      default: pin_limit = 16'h0078;
    endcase
  endfunction

endpackage

// ### pos_seq_props.sv
// Checker of the sequencer top ports
// Assumes a bind to pos_seq_top with its half-ms count
`timescale 1ns/1ps
module pos_seq_props #(
  parameter int HALF_MS_CYC = 20
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic start_cond,
  input wire logic soft_stop_en,
  input wire logic vout_low,
  input wire logic [15:0] vout_target,
  input wire logic [15:0] input_power,
  input wire logic [15:0] ref_dac,
  input wire logic switching_en,
  input wire logic stage_tristate,
  input wire logic input_power_warn,
  input wire logic input_power_over
);
  // ----------
  // Properties
  // ----------
  int hi_cnt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      hi_cnt <= 0;
    else if (!start_cond)
      hi_cnt <= 0;
    else if (hi_cnt < 9999)
      hi_cnt <= hi_cnt + 1;
  end
  property p_tri;
    stage_tristate == !switching_en;
  endproperty
  a_tri: assert property (p_tri) else $error("tristate mismatch");
  property p_ton;
    $rose(switching_en) |-> hi_cnt >= HALF_MS_CYC
      && hi_cnt <= 4 * HALF_MS_CYC + 24;
  endproperty
  a_ton: assert property (p_ton) else $error("turn-on delay");
  property p_rise0;
    $rose(switching_en) |-> $past(ref_dac) == 16'h0000;
  endproperty
  a_rise0: assert property (p_rise0) else $error("ramp start");
  property p_up;
    start_cond [*4] ##0 switching_en |->
      ref_dac <= $past(ref_dac) + 16'h0001 || ref_dac == vout_target;
  endproperty
  a_up: assert property (p_up) else $error("ramp up step");
  property p_down;
    !start_cond [*6] |-> ref_dac <= $past(ref_dac);
  endproperty
  a_down: assert property (p_down) else $error("ramp down");
  property p_stopnow;
    (!start_cond && !soft_stop_en) [*6] |-> !switching_en
      && ref_dac == 16'h0000;
  endproperty
  a_stopnow: assert property (p_stopnow) else $error("no fast stop");
  property p_vlow;
    (!start_cond && vout_low) [*6] |-> !switching_en;
  endproperty
  a_vlow: assert property (p_vlow) else $error("low output");
  property p_over_hi;
    input_power > 16'h01fe |=> input_power_over;
  endproperty
  a_over_hi: assert property (p_over_hi) else $error("over");
  property p_over_lo;
    input_power <= 16'h0078 |=> !input_power_over;
  endproperty
  a_over_lo: assert property (p_over_lo) else $error("under");
  property p_warn;
    input_power_over |-> ##[0:1] input_power_warn;
  endproperty
  a_warn: assert property (p_warn) else $error("warn flag");
endmodule

// ### pos_seq_top.sv
// Power on/off sequencer with byte-wide I2C settings
// Function
// - Start condition waits turn-on delay first
// - Turn-on delay codes: 0.5, 1, 1.5, 2 ms
// - Soft-start time sets reference ramp rate
// - Soft-start codes: 1,2,4,8 ms, else 16
// - Exact only under processor bus setpoint
// - Stop condition waits turn-off delay first
// - Turn-off delay codes: 0, 1, 1.5, 2 ms
// - Soft-stop disabled: tri-state at once
// - Ramp reference to zero over soft-stop time
// - Soft-stop codes: 0.5, 1, 2, 4 ms
// - Tri-state once output reaches 200 mV
// - Compare input power against threshold continuously
// - Excess input power sets warning flag
// - Thresholds 510 down to 120 W
// - Warning threshold doubles as maximum threshold
// - Unused upper setting bits read zero
// - Byte read/write, applied live, backed up
// - Soft-start from NVM or strap pins
// Assumes pins are asynchronous; telemetry and setpoint on this clock
`timescale 1ns/1ps
module pos_seq_top #(
  parameter int HALF_MS_CYC = pos_pkg::HALF_MS_CYCLES,
  parameter logic [6:0] I2C_ADDR = pos_pkg::DEF_I2C_ADDR
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic start_cond,
  input wire logic soft_stop_en,
  input wire logic vout_low,
  input wire logic strap_use,
  input wire logic [pos_pkg::SS_W-1:0] strap_code,
  input wire logic [15:0] vout_target,
  input wire logic [15:0] input_power,
  output logic [15:0] ref_dac,
  output logic switching_en,
  output logic stage_tristate,
  output logic input_power_warn,
  output logic input_power_over
);
  import pos_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic scl_d;
  logic sda_d;
  logic scl_s, sda_s, start_s, stopen_s, low_s, strap_s;
  logic [SS_W-1:0] strap_code_s;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= 9'h003;
      sync2 <= 9'h003;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sync1 <= {strap_code, strap_use, vout_low, soft_stop_en, start_cond,
                sda_in, scl_in};
      sync2 <= sync1;
      scl_d <= sync2[0];
      sda_d <= sync2[1];
    end
  end

  assign scl_s = sync2[0];
  assign sda_s = sync2[1];
  assign start_s = sync2[2];
  assign stopen_s = sync2[3];
  assign low_s = sync2[4];
  assign strap_s = sync2[5];
  assign strap_code_s = sync2[8:6];

  // ------------------------------------------------------------
  // I2C slave: write byte and read byte
  // ------------------------------------------------------------
  pos_bus_e bus_st;
  pos_bus_e bus_after;
  logic [7:0] shreg;
  logic [3:0] bitc;
  logic [7:0] cmd;
  logic wr_pulse;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic bus_start, bus_stop, scl_rise, scl_fall;

  assign bus_start = scl_s & sda_d & ~sda_s;
  assign bus_stop = scl_s & ~sda_d & sda_s;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign sda_out = 1'b0;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bus_st <= BUS_IDLE;
      bus_after <= BUS_IDLE;
      shreg <= 8'h00;
      bitc <= 4'h0;
      cmd <= 8'h00;
      sda_oe <= 1'b0;
      wr_pulse <= 1'b0;
      wr_byte <= 8'h00;
    end else begin
      wr_pulse <= 1'b0;
      if (bus_start) begin
        bus_st <= BUS_ADDR;
        bitc <= 4'h0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        bus_st <= BUS_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (bus_st)
          BUS_ADDR, BUS_CMD, BUS_WDAT: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitc <= bitc + 4'h1;
            end else if (scl_fall && bitc == 4'h8) begin
              bitc <= 4'h0;
              bus_st <= BUS_ACK;
              sda_oe <= 1'b1;
              if (bus_st == BUS_ADDR) begin
                if (shreg[7:1] != I2C_ADDR) begin
                  bus_st <= BUS_IDLE;
                  sda_oe <= 1'b0;
                end
                bus_after <= shreg[0] ? BUS_RDAT : BUS_CMD;
              end else if (bus_st == BUS_CMD) begin
                cmd <= shreg;
                bus_after <= BUS_WDAT;
              end else begin
                wr_pulse <= 1'b1;
                wr_byte <= shreg;
                bus_after <= BUS_WDAT;
              end
            end
          end
          BUS_ACK: begin
            if (scl_fall) begin
              bus_st <= bus_after;
              sda_oe <= 1'b0;
              if (bus_after == BUS_RDAT) begin
                shreg <= {rd_byte[6:0], 1'b0};
                sda_oe <= ~rd_byte[7];
              end
            end
          end
          BUS_RDAT: begin
            if (scl_rise) begin
              bitc <= bitc + 4'h1;
            end else if (scl_fall) begin
              if (bitc == 4'h8) begin
                bitc <= 4'h0;
                sda_oe <= 1'b0;
                bus_st <= BUS_MACK;
              end else begin
                sda_oe <= ~shreg[7];
                shreg <= {shreg[6:0], 1'b0};
              end
            end
          end
          BUS_MACK: begin
            if (scl_rise) begin
              bus_st <= BUS_IDLE;
            end
          end
          BUS_IDLE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            bus_st <= BUS_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Settings, NVM load after reset and backup on write
  // ------------------------------------------------------------
  pos_cfg_s cfg;
  logic load_busy;
  logic load_valid;
  logic [2:0] load_idx;
  logic [2:0] load_slot;
  logic [7:0] nvm_rd;
  logic nvm_we;
  logic [2:0] nvm_wa;
  logic warn_flag;
  logic over;

  always_comb begin
    nvm_we = 1'b0;
    nvm_wa = NVM_TON;
    case (cmd)
      CMD_TURN_ON_DELAY: begin
        nvm_we = wr_pulse;
        nvm_wa = NVM_TON;
      end
      CMD_SOFT_START: begin
        nvm_we = wr_pulse;
        nvm_wa = NVM_SS;
      end
      CMD_TURN_OFF_DELAY: begin
        nvm_we = wr_pulse;
        nvm_wa = NVM_TOFF;
      end
      CMD_SOFT_STOP: begin
        nvm_we = wr_pulse;
        nvm_wa = NVM_SSTOP;
      end
      CMD_INPUT_POWER_LIMIT: begin
        nvm_we = wr_pulse;
        nvm_wa = NVM_PIN;
      end
      default: begin
        nvm_we = 1'b0;
      end
    endcase
  end

  pos_nvm u_nvm (
    .clock(clock),
    .sys_rst(sys_rst),
    .wr_en(nvm_we),
    .wr_addr(nvm_wa),
    .wr_data(wr_byte),
    .rd_addr(load_idx),
    .rd_data(nvm_rd)
  );

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      load_busy <= 1'b1;
      load_valid <= 1'b0;
      load_idx <= NVM_TON;
      load_slot <= NVM_TON;
      cfg <= '0;
    end else begin
      load_valid <= load_busy;
      load_slot <= load_idx;
      if (load_busy) begin
        if (load_idx == NVM_LAST) begin
          load_busy <= 1'b0;
        end else begin
          load_idx <= load_idx + 3'h1;
        end
      end
      if (load_valid) begin
        case (load_slot)
          NVM_TON: cfg.ton <= nvm_rd[TON_W-1:0];
          NVM_SS: cfg.ss <= strap_s ? strap_code_s : nvm_rd[SS_W-1:0];
          NVM_TOFF: cfg.toff <= nvm_rd[TOFF_W-1:0];
          NVM_SSTOP: cfg.sstop <= nvm_rd[SSTOP_W-1:0];
          default: cfg.pin <= nvm_rd[PIN_W-1:0];
        endcase
      end else if (wr_pulse) begin
        case (cmd)
          CMD_TURN_ON_DELAY: cfg.ton <= wr_byte[TON_W-1:0];
          CMD_SOFT_START: cfg.ss <= wr_byte[SS_W-1:0];
          CMD_TURN_OFF_DELAY: cfg.toff <= wr_byte[TOFF_W-1:0];
          CMD_SOFT_STOP: cfg.sstop <= wr_byte[SSTOP_W-1:0];
          CMD_INPUT_POWER_LIMIT: cfg.pin <= wr_byte[PIN_W-1:0];
          default: cfg.pin <= cfg.pin;
        endcase
      end
    end
  end

  // Read data, upper bits zero
  always_comb begin
    case (cmd)
      CMD_TURN_ON_DELAY: rd_byte = {6'h00, cfg.ton};
      CMD_SOFT_START: rd_byte = {5'h00, cfg.ss};
      CMD_TURN_OFF_DELAY: rd_byte = {6'h00, cfg.toff};
      CMD_SOFT_STOP: rd_byte = {6'h00, cfg.sstop};
      CMD_INPUT_POWER_LIMIT: rd_byte = {5'h00, cfg.pin};
      CMD_STATUS_INPUT: rd_byte = {7'h00, warn_flag};
      default: rd_byte = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Input power comparator and warning flag
  // ------------------------------------------------------------
  assign over = input_power > pin_limit(cfg.pin);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      warn_flag <= 1'b0;
      input_power_over <= 1'b0;
    end else begin
      input_power_over <= over;
      if (over) begin
        warn_flag <= 1'b1;
      end else if (wr_pulse && cmd == CMD_STATUS_INPUT &&
                   wr_byte[STAT_PIN_WARN_BIT]) begin
        warn_flag <= 1'b0;
      end
    end
  end

  assign input_power_warn = warn_flag;

  // ------------------------------------------------------------
  // Sequencer with reference ramp
  // ------------------------------------------------------------
  pos_seq_e seq;
  logic [23:0] tmr;
  logic [23:0] span_cyc;
  logic [24:0] acc;
  logic [15:0] span;
  logic [24:0] next_acc;
  logic step;

  function automatic logic [23:0] to_cyc(input logic [5:0] units);
    to_cyc = 24'(units) * 24'(HALF_MS_CYC);
  endfunction

  // Spread span steps evenly over span_cyc cycles
  assign next_acc = acc + 25'(span);
  assign step = next_acc >= 25'(span_cyc);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      seq <= SEQ_OFF;
      tmr <= 24'h000000;
      span_cyc <= 24'h000001;
      acc <= 25'h0000000;
      span <= 16'h0000;
      ref_dac <= 16'h0000;
      switching_en <= 1'b0;
    end else begin
      case (seq)
        SEQ_OFF: begin
          ref_dac <= 16'h0000;
          switching_en <= 1'b0;
          if (start_s && !load_busy && !load_valid) begin
            seq <= SEQ_TON;
            tmr <= to_cyc(ton_units(cfg.ton));
          end
        end
        SEQ_TON: begin
          if (!start_s) begin
            seq <= SEQ_OFF;
          end else if (tmr <= 24'h000001) begin
            seq <= SEQ_RISE;
            switching_en <= 1'b1;
            span <= vout_target;
            span_cyc <= to_cyc(ss_units(cfg.ss));
            tmr <= to_cyc(ss_units(cfg.ss));
            acc <= 25'h0000000;
          end else begin
            tmr <= tmr - 24'h000001;
          end
        end
        SEQ_RISE: begin
          // Duration matches selection for a fixed setpoint only
          if (step) begin
            acc <= next_acc - 25'(span_cyc);
            ref_dac <= ref_dac + 16'h0001;
          end else begin
            acc <= next_acc;
          end
          if (!start_s) begin
            seq <= SEQ_TOFF;
            tmr <= to_cyc(toff_units(cfg.toff));
          end else if (tmr <= 24'h000001) begin
            seq <= SEQ_REG;
            ref_dac <= vout_target;
          end else begin
            tmr <= tmr - 24'h000001;
          end
        end
        SEQ_REG: begin
          ref_dac <= vout_target;
          if (!start_s) begin
            seq <= SEQ_TOFF;
            tmr <= to_cyc(toff_units(cfg.toff));
          end
        end
        SEQ_TOFF: begin
          if (tmr <= 24'h000001) begin
            seq <= SEQ_FALL;
            span <= ref_dac;
            span_cyc <= to_cyc(sstop_units(cfg.sstop));
            tmr <= to_cyc(sstop_units(cfg.sstop));
            acc <= 25'h0000000;
          end else begin
            tmr <= tmr - 24'h000001;
          end
        end
        SEQ_FALL: begin
          if (step && ref_dac != 16'h0000) begin
            acc <= next_acc - 25'(span_cyc);
            ref_dac <= ref_dac - 16'h0001;
          end else begin
            acc <= next_acc;
          end
          if (tmr <= 24'h000001) begin
            ref_dac <= 16'h0000;
          end else begin
            tmr <= tmr - 24'h000001;
          end
          if (low_s) begin
            seq <= SEQ_OFF;
            switching_en <= 1'b0;
            ref_dac <= 16'h0000;
          end
        end
        default: begin
          seq <= SEQ_OFF;
          switching_en <= 1'b0;
        end
      endcase
      // Soft-stop disabled: no delay, no ramp
      if (!stopen_s && !start_s && seq != SEQ_OFF) begin
        seq <= SEQ_OFF;
        switching_en <= 1'b0;
        ref_dac <= 16'h0000;
      end
    end
  end

  assign stage_tristate = ~switching_en;

endmodule

// ### test_power_on_off_sequencer.sv
// Self-checking bench of the power sequencer
// Assumes the host model and the checker are compiled first
`timescale 1ns/1ps
module test_power_on_off_sequencer;
  import pos_pkg::*;
  // -----
  // Bench
  // -----
  localparam int H = 20;
  localparam logic [6:0] ADR = 7'h2c;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic start_cond = 1'b0;
  logic soft_stop_en = 1'b1;
  logic vout_low = 1'b0;
  logic strap_use = 1'b1;
  logic [2:0] strap_code = 3'h6;
  logic [15:0] vout_target = 16'h0008;
  logic [15:0] input_power = 16'h0000;
  logic scl, sda, sda_out, sda_oe, rx_valid;
  logic switching_en, stage_tristate, input_power_warn, input_power_over;
  logic [7:0] rx_byte;
  logic [15:0] ref_dac;
  logic [31:0] seed = 32'h0000005a;
  logic [7:0] exp_q[$];
  int errors = 0;
  int compares = 0;
  int ton_u[4] = '{1, 2, 3, 4};
  int ss_u[4] = '{2, 4, 8, 32};
  int toff_u[4] = '{0, 2, 3, 4};
  int sstop_u[4] = '{1, 2, 4, 8};
  int pw[8] = '{510, 480, 420, 360, 300, 240, 180, 120};
  logic [7:0] cmds[5] = '{8'h60, 8'h61, 8'h64, 8'h65, 8'h6b};
  logic [7:0] mask[5] = '{8'h03, 8'h07, 8'h03, 8'h03, 8'h07};
  logic [7:0] dflt[5] = '{8'h00, 8'h06, 8'h00, 8'h00, 8'h00};
  pos_seq_top #(.HALF_MS_CYC(H), .I2C_ADDR(ADR)) uut (
    .clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .start_cond(start_cond),
    .soft_stop_en(soft_stop_en), .vout_low(vout_low),
    .strap_use(strap_use), .strap_code(strap_code),
    .vout_target(vout_target), .input_power(input_power),
    .ref_dac(ref_dac), .switching_en(switching_en),
    .stage_tristate(stage_tristate), .input_power_warn(input_power_warn),
    .input_power_over(input_power_over)
  );
  pos_i2c_host host (
    .clock(clock), .sda_out(sda_out), .sda_oe(sda_oe), .scl(scl),
    .sda(sda), .rx_valid(rx_valid), .rx_byte(rx_byte)
  );
  initial begin
    forever #5 clock = ~clock;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic final_report();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      errors++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  function automatic logic hit(input int k);
    case (k)
      0: hit = switching_en;
      1: hit = ref_dac == vout_target;
      2: hit = ref_dac < vout_target;
      3: hit = ref_dac == 16'h0000;
      default: hit = !switching_en;
    endcase
  endfunction
  task automatic wt(input int k, input int lo, input int hi);
    int n;
    n = 0;
    while (hit(k) !== 1'b1 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    chk(n >= lo && n <= hi, "timing");
    if (n >= 2000)
      final_report();
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic ok;
    host.wr(ADR, c, d, ok);
    chk(ok, "no ack");
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(ADR, c);
  endtask
  task automatic seq(input int i);
    int t, a, b;
    t = ton_u[i] * H;
    a = toff_u[i] * H;
    b = sstop_u[i] * H;
    wr(CMD_TURN_ON_DELAY, 8'(i));
    wr(CMD_SOFT_START, (i == 3) ? 8'h05 : 8'(i));
    wr(CMD_TURN_OFF_DELAY, 8'(i));
    wr(CMD_SOFT_STOP, 8'(i));
    vout_low <= 1'b0;
    start_cond <= 1'b1;
    wt(0, t, t + 10);
    wt(1, ss_u[i] * H - 4, ss_u[i] * H + 6);
    repeat (5) @(posedge clock);
    start_cond <= 1'b0;
    wt(2, a, a + b / 4 + 8);
    if (i != 3)
      wt(3, b * 3 / 4 - 8, b + 6);
    vout_low <= 1'b1;
    wt(4, 0, 8);
  endtask
  always @(posedge clock) begin
    if (rx_valid) begin
      compares++;
      if (exp_q.size() == 0 || rx_byte !== exp_q[0]) begin
        errors++;
        $display("Error %0t: read %h", $time, rx_byte);
      end
      if (exp_q.size() != 0)
        void'(exp_q.pop_front());
    end
  end
  initial begin
    logic ok;
    logic [7:0] v;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (12) @(posedge clock);
    host.wr(7'h2d, CMD_TURN_ON_DELAY, 8'h03, ok);
    chk(ok === 1'b0, "foreign address acked");
    for (int r = 0; r < 5; r++) begin
      rd(cmds[r], dflt[r]);
      wr(cmds[r], 8'hff);
      rd(cmds[r], mask[r]);
      v = 8'(xs());
      wr(cmds[r], v);
      rd(cmds[r], v & mask[r]);
    end
    rd(8'h70, 8'h00);
    start_cond <= 1'b1;
    repeat (H / 2) @(posedge clock);
    start_cond <= 1'b0;
    repeat (5 * H) @(posedge clock);
    chk(switching_en === 1'b0, "started early");
    for (int i = 0; i < 4; i++)
      seq(i);
    wr(CMD_SOFT_START, 8'h03);
    vout_low <= 1'b0;
    start_cond <= 1'b1;
    wt(1, 398, 410);
    soft_stop_en <= 1'b0;
    start_cond <= 1'b0;
    wt(4, 0, 6);
    @(posedge clock);
    chk(ref_dac === 16'h0000, "ref not zero");
    for (int c = 0; c < 8; c++) begin
      wr(CMD_INPUT_POWER_LIMIT, 8'(c));
      input_power <= 16'(pw[c]);
      repeat (4) @(posedge clock);
      chk(input_power_over === 1'b0, "over at limit");
      input_power <= 16'(pw[c] + 1 + xs() % 64);
      repeat (4) @(posedge clock);
      chk(input_power_warn === 1'b1, "no warning");
      wr(CMD_STATUS_INPUT, 8'h01);
      rd(CMD_STATUS_INPUT, 8'h01);
      input_power <= 16'h0000;
      wr(CMD_STATUS_INPUT, 8'h01);
      rd(CMD_STATUS_INPUT, 8'h00);
    end
    repeat (10) @(posedge clock);
    final_report();
  end
endmodule
bind pos_seq_top pos_seq_props #(.HALF_MS_CYC(HALF_MS_CYC)) u_props (
  .clock(clock), .sys_rst(sys_rst), .start_cond(start_cond),
  .soft_stop_en(soft_stop_en), .vout_low(vout_low),
  .vout_target(vout_target), .input_power(input_power),
  .ref_dac(ref_dac), .switching_en(switching_en),
  .stage_tristate(stage_tristate), .input_power_warn(input_power_warn),
  .input_power_over(input_power_over)
);
